// ==== dv/sixteen_bit_timer_counter_tb.sv ====
`timescale 1ns/10ps
module sixteen_bit_timer_counter_tb import stc_pkg::*; ;
  logic              sys_clk = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic              s_axi_rvalid, s_axi_rready, cc_special_event, osc_run, irq;
  logic [1:0]        s_axi_bresp, s_axi_rresp, osc_pin_i, osc_pin_o, osc_pin_oe_n;
  logic [1:0]        port_direction_bits, port_out_bits, port_read_bits;
  logic [31:0]       rd;
  int                mismatches, num_checks, cycles;
  logic              late_b = 1'b0;

  always #20 sys_clk = ~sys_clk;

  stc_timer dut_u (.sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .cc_special_event(cc_special_event), .osc_pin_i(osc_pin_i), .osc_pin_o(osc_pin_o),
    .osc_pin_oe_n(osc_pin_oe_n), .port_direction_bits(port_direction_bits),
    .port_out_bits(port_out_bits), .port_read_bits(port_read_bits), .osc_run(osc_run),
    .irq(irq));

  stc_pin_model pin_u (.sys_clk(sys_clk), .pin(osc_pin_i));

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= ~late_b;
    // Late mode lets the response wait a cycle before it is taken
    do begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1 && !s_axi_bready) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid === 1'b1 && s_axi_bready));
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er, "bresp");
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    chk(s_axi_rresp, er, "rresp");
  endtask : axi_rd

  task automatic clr_count();
    axi_wr(OFF_CNT_LO, 32'h0, RESP_OKAY);
    axi_wr(OFF_CNT_HI, 32'h0, RESP_OKAY);
  endtask : clr_count

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    logic [7:0] offs [5];
    offs = '{OFF_CTRL, OFF_CNT_LO, OFF_CNT_HI, OFF_IRQ_STAT, OFF_IRQ_MASK};
    foreach (offs[i]) begin
      axi_rd(offs[i], RESP_OKAY);
      chk(rd, 32'h0, "reset value");
    end
    chk(osc_run, 1'b0, "osc_run at reset");
  endtask : t_reset

  task automatic t_ctrl();
    logic pin_b;
    axi_wr(OFF_CTRL, 32'hff, RESP_OKAY);
    axi_rd(OFF_CTRL, RESP_OKAY);
    chk(rd, 32'h3f, "ctrl readback");
    @(negedge sys_clk);
    chk(osc_run, 1'b1, "osc on");
    chk(osc_pin_oe_n, 2'b11, "pins input");
    chk(port_read_bits, 2'b00, "pins read zero");
    chk(osc_pin_o, 2'b10, "pin drive passthrough");
    axi_wr(OFF_CTRL, 32'h00, RESP_OKAY);
    @(negedge sys_clk);
    chk(osc_run, 1'b0, "osc off");
    chk(osc_pin_oe_n, 2'b00, "pins driven");
    // Input pin toggles every cycle, so its read must too
    pin_b = port_read_bits[1];
    @(negedge sys_clk);
    chk(port_read_bits[1], !pin_b, "pin read follows pin");
  endtask : t_ctrl

  task automatic t_rate();
    logic [31:0] held;
    for (int ps = 0; ps < 4; ps++) begin
      clr_count();
      // Sync bit toggled too: it must not matter with the internal source
      axi_wr(OFF_CTRL, 32'(ps << 4) | (32'(ps[0]) << 2) | 32'h1, RESP_OKAY);
      repeat (40 << ps) @(posedge sys_clk);
      axi_wr(OFF_CTRL, 32'h0, RESP_OKAY);
      axi_rd(OFF_CNT_LO, RESP_OKAY);
      held = rd;
      chk(32'(rd >= 9 && rd <= 11), 32'h1, "timer rate");
      repeat (50) @(posedge sys_clk);
      axi_rd(OFF_CNT_LO, RESP_OKAY);
      chk(rd, held, "stopped count holds");
    end
  endtask : t_rate

  task automatic t_ext();
    for (int s = 0; s < 2; s++) begin
      axi_wr(OFF_CTRL, 32'h3 | 32'(s << 2), RESP_OKAY);
      clr_count();
      pin_u.pulses(5, 6);
      repeat (12) @(posedge sys_clk);
      axi_rd(OFF_CNT_LO, RESP_OKAY);
      chk(rd, 32'h5, "edge count");
    end
    axi_wr(OFF_CTRL, 32'h13, RESP_OKAY);
    clr_count();
    pin_u.pulses(6, 6);
    repeat (12) @(posedge sys_clk);
    axi_rd(OFF_CNT_LO, RESP_OKAY);
    chk(rd, 32'h3, "edge count 1:2");
  endtask : t_ext

  task automatic t_wrap();
    axi_wr(OFF_CTRL, 32'h0, RESP_OKAY);
    axi_wr(OFF_CNT_HI, 32'hff, RESP_OKAY);
    axi_wr(OFF_CNT_LO, 32'hff, RESP_OKAY);
    axi_wr(OFF_CTRL, 32'h1, RESP_OKAY);
    repeat (40) @(posedge sys_clk);
    axi_wr(OFF_CTRL, 32'h0, RESP_OKAY);
    axi_rd(OFF_CNT_HI, RESP_OKAY);
    chk(rd, 32'h0, "wrapped high byte");
    @(negedge sys_clk);
    chk(irq, 1'b0, "masked irq");
    axi_wr(OFF_IRQ_MASK, 32'h1, RESP_OKAY);
    @(negedge sys_clk);
    chk(irq, 1'b1, "irq raised");
    axi_rd(OFF_IRQ_STAT, RESP_OKAY);
    chk(rd, 32'h1, "overflow flag");
    axi_rd(OFF_IRQ_STAT, RESP_OKAY);
    chk(rd, 32'h0, "flag cleared by read");
    @(negedge sys_clk);
    chk(irq, 1'b0, "irq cleared");
  endtask : t_wrap

  task automatic t_event();
    axi_wr(OFF_CNT_LO, 32'h55, RESP_OKAY);
    axi_wr(OFF_CNT_HI, 32'haa, RESP_OKAY);
    axi_rd(OFF_CNT_LO, RESP_OKAY);
    chk(rd, 32'h55, "count write");
    axi_rd(OFF_CNT_HI, RESP_OKAY);
    chk(rd, 32'haa, "count high write");
    @(posedge sys_clk);
    cc_special_event <= 1'b1;
    @(posedge sys_clk);
    cc_special_event <= 1'b0;
    axi_rd(OFF_CNT_LO, RESP_OKAY);
    chk(rd, 32'h0, "event clears count");
    axi_rd(OFF_CNT_HI, RESP_OKAY);
    chk(rd, 32'h0, "event clears high byte");
  endtask : t_event

  task automatic t_unmapped();
    axi_wr(8'h40, 32'h5a, RESP_SLVERR);
    axi_rd(8'h40, RESP_SLVERR);
    chk(rd, 32'h0, "unmapped read");
    // Lane zero off: write answered but mask keeps its set bit
    late_b = 1'b1;
    s_axi_wstrb <= 4'h0;
    axi_wr(OFF_IRQ_MASK, 32'h0, RESP_OKAY);
    late_b = 1'b0;
    s_axi_wstrb <= 4'hf;
    axi_rd(OFF_IRQ_MASK, RESP_OKAY);
    chk(rd, 32'h1, "lane off leaves mask");
  endtask : t_unmapped

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and hang guard
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      $display("Error at %0t: run timed out", $time);
      conclude();
    end
  end

  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    cc_special_event = 1'b0;
    port_direction_bits = 2'b00;
    port_out_bits = 2'b10;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_ctrl();
    t_rate();
    t_ext();
    t_wrap();
    t_event();
    t_unmapped();
    conclude();
  end
endmodule : sixteen_bit_timer_counter_tb

// ==== dv/stc_pin_model.sv ====
`timescale 1ns/10ps
module stc_pin_model (
  // Clock
  input  wire logic       sys_clk,
  // Pin levels toward the block
  output logic [1:0]      pin
);
  logic cnt_pin_q;
  logic osc_in_q;

  ////////////////////////////////////////////////////////////////////////////
  // Unloaded crystal input has no pull, so it wanders every cycle
  initial cnt_pin_q = 1'b0;
  initial osc_in_q = 1'b0;
  always @(posedge sys_clk) osc_in_q <= ~osc_in_q;
  assign pin = {osc_in_q, cnt_pin_q};

  ////////////////////////////////////////////////////////////////////////////
  // Count clock stands low between bursts
  task automatic pulses(input int n, input int half);
    repeat (n) begin
      @(posedge sys_clk);
      cnt_pin_q <= 1'b1;
      repeat (half) @(posedge sys_clk);
      cnt_pin_q <= 1'b0;
      repeat (half) @(posedge sys_clk);
    end
  endtask : pulses
endmodule : stc_pin_model

// ==== hdl/stc_pkg.sv ====
package stc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam logic [1:0]  RESP_OKAY       = 2'b00;
  localparam logic [1:0]  RESP_SLVERR     = 2'b10;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0]  OFF_CTRL        = 8'h10;
  localparam logic [7:0]  OFF_CNT_LO      = 8'h14;
  localparam logic [7:0]  OFF_CNT_HI      = 8'h18;
  localparam logic [7:0]  OFF_IRQ_STAT    = 8'h1c;
  localparam logic [7:0]  OFF_IRQ_MASK    = 8'h20;

  ////////////////////////////////////////////////////////////////////////////
  // Control field positions
  localparam int          CTRL_ON_BIT     = 0;
  localparam int          CTRL_CS_BIT     = 1;
  localparam int          CTRL_SYNC_BIT   = 2;
  localparam int          CTRL_OSC_BIT    = 3;
  localparam int          CTRL_PS_LSB     = 4;
  localparam int          CTRL_PS_MSB     = 5;
  localparam logic [7:0]  CTRL_IMPL_MASK  = 8'h3f;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and count limit
  localparam logic [7:0]  CTRL_RST        = 8'h00;
  localparam logic [15:0] CNT_RST         = 16'h0000;
  localparam logic [15:0] CNT_MAX         = 16'hffff;
  localparam logic        STAT_RST        = 1'b0;
  localparam logic        MASK_RST        = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: one instruction cycle is four oscillator clocks
  localparam int          CLK_HZ          = 25_000_000;
  localparam int          OSC_PER_INSTR   = 4;
  localparam logic [1:0]  INSTR_DIV_MAX   = 2'(OSC_PER_INSTR - 1);
  localparam int          PS_W            = 3;
  localparam logic [2:0]  PS_RST          = 3'h0;

endpackage : stc_pkg

// ==== hdl/stc_prescale.sv ====
`timescale 1ns/10ps
module stc_prescale import stc_pkg::*; (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Control
  input  wire logic       clr,
  input  wire logic [1:0] sel,
  // Ticks
  input  wire logic       tick_in,
  output logic            tick_out
);

  logic [PS_W-1:0] cnt_q;
  logic [PS_W-1:0] cnt_d;
  logic [PS_W-1:0] ratio_mask;

  // Ratio 1:1, 1:2, 1:4, 1:8 as a mask of low count bits
  function automatic logic [PS_W-1:0] ps_mask(input logic [1:0] s);
    ps_mask = 3'((4'h1 << s) - 4'h1);
  endfunction : ps_mask

  assign ratio_mask = ps_mask(sel);
  assign tick_out   = tick_in & ((cnt_q & ratio_mask) == ratio_mask);
  assign cnt_d      = clr ? PS_RST : (tick_in ? cnt_q + 3'h1 : cnt_q);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= PS_RST;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule : stc_prescale

// ==== hdl/stc_sync2.sv ====
`timescale 1ns/10ps
module stc_sync2 import stc_pkg::*; (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Level in and out
  input  wire logic d,
  output logic      q
);

  logic meta_q;

  // First stage feeds only the second
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_q <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : stc_sync2

// ==== hdl/stc_timer.sv ====
// Notes on behaviour
// - Timer, synchronous or asynchronous counter modes
// - Timer mode counts each instruction cycle
// - Counter mode counts external rising edges
// - Counter-on bit runs or holds count
// - Special event trigger clears the count
// - Oscillator on: pins inputs, read zero
// - Control bits 7 and 6 read zero
// - Prescale codes give 1:1, 1:2, 1:4, 1:8
// - Oscillator runs only while enable set
// - Sync bit picks synchronised or raw counting
// - Internal source ignores the sync bit
// - Source select: pin edge or Fosc/4
// - Two byte halves, wraps ffff to 0000
// - Wrap sets latched overflow flag, interrupt
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/10ps
module stc_timer import stc_pkg::*; (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Capture/compare special event
  input  wire logic              cc_special_event,
  // Oscillator pins, bit 0 count/output pin, bit 1 input pin
  input  wire logic [1:0]        osc_pin_i,
  output logic [1:0]             osc_pin_o,
  output logic [1:0]             osc_pin_oe_n,
  // Port side of the two pins
  input  wire logic [1:0]        port_direction_bits,
  input  wire logic [1:0]        port_out_bits,
  output logic [1:0]             port_read_bits,
  // Oscillator and interrupt
  output logic                   osc_run,
  output logic                   irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0]        ctrl_q;
  logic [15:0]       count_q;
  logic [15:0]       count_d;
  logic              stat_q;
  logic              mask_q;
  logic [1:0]        div_q;
  logic              rise_prev_q;
  logic [1:0]        pin_s;
  logic              instr_tick;
  logic              pin_rise;
  logic              ext_mode;
  logic              sync_path;
  logic              src_tick;
  logic              presc_in;
  logic              presc_tick;
  logic              presc_sync;
  logic              inc;
  logic              wrap;
  logic              ovf_set;
  logic              cnt_we;
  // Write channel state
  logic              aw_hold_q;
  logic              w_hold_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0]        wdata_q;
  logic              wlane_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              aw_take;
  logic              w_take;
  logic              do_wr;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0]        wr_byte;
  logic              wr_lane;
  logic              wr_known;
  logic              we_ctrl;
  logic              we_lo;
  logic              we_hi;
  logic              we_mask;
  // Read channel state
  logic              rvalid_q;
  logic [7:0]        rbyte_q;
  logic [1:0]        rresp_q;
  logic              ar_take;
  logic              rd_known;
  logic [7:0]        rd_byte;
  logic              stat_rd_clr;

  // Word decode shared by both channels
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
  endfunction : hit
  function automatic logic known(input logic [ADDR_W-1:0] a);
    known = hit(a, OFF_CTRL) | hit(a, OFF_CNT_LO) | hit(a, OFF_CNT_HI)
          | hit(a, OFF_IRQ_STAT) | hit(a, OFF_IRQ_MASK);
  endfunction : known

  ////////////////////////////////////////////////////////////////////////////
  // Pins and oscillator
  for (genvar g = 0; g < 2; g++) begin : g_pin_sync
    stc_sync2 u_pin_sync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .d       (osc_pin_i[g]),
      .q       (pin_s[g])
    );
  end

  // Crystal owns both pins while enabled, whatever the direction bits say
  assign osc_pin_oe_n   = (port_direction_bits | {2{ctrl_q[CTRL_OSC_BIT]}});
  assign osc_pin_o      = port_out_bits;
  assign port_read_bits = ctrl_q[CTRL_OSC_BIT] ? 2'b00 : pin_s;
  assign osc_run        = ctrl_q[CTRL_OSC_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Count source
  assign instr_tick = (div_q == INSTR_DIV_MAX);
  assign pin_rise   = pin_s[0] & ~rise_prev_q;
  assign ext_mode   = ctrl_q[CTRL_CS_BIT];
  assign sync_path  = ext_mode & ~ctrl_q[CTRL_SYNC_BIT];
  assign src_tick   = ext_mode ? pin_rise : instr_tick;
  assign presc_in   = ctrl_q[CTRL_ON_BIT] & src_tick;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_q       <= 2'h0;
      rise_prev_q <= 1'b0;
    end else begin
      div_q       <= instr_tick ? 2'h0 : div_q + 2'h1;
      rise_prev_q <= pin_s[0];
    end
  end
  stc_prescale u_prescale (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .clr      (cnt_we | cc_special_event),
    .sel      (ctrl_q[CTRL_PS_MSB:CTRL_PS_LSB]),
    .tick_in  (presc_in),
    .tick_out (presc_tick)
  );
  // Costs two cycles of latency but aligns edges to the core clock
  stc_sync2 u_evt_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .d       (presc_tick),
    .q       (presc_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Counter
  assign inc     = ctrl_q[CTRL_ON_BIT] & (sync_path ? presc_sync : presc_tick);
  assign wrap    = inc & (count_q == CNT_MAX);
  assign cnt_we  = we_lo | we_hi;
  assign ovf_set = wrap & ~cc_special_event & ~cnt_we;
  assign count_d = cc_special_event ? CNT_RST :
                   we_lo ? {count_q[15:8], wr_byte} :
                   we_hi ? {wr_byte, count_q[7:0]} :
                   inc   ? count_q + 16'h0001 : count_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count_q <= CNT_RST;
    end else begin
      count_q <= count_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt
  // A wrap in the read-clear cycle survives
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stat_q <= STAT_RST;
    end else begin
      stat_q <= ovf_set | (stat_q & ~stat_rd_clr);
    end
  end

  assign irq = stat_q & mask_q;

  ////////////////////////////////////////////////////////////////////////////
  // Write channel
  assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
  assign s_axi_wready  = ~w_hold_q & ~bvalid_q;
  assign aw_take       = s_axi_awvalid & s_axi_awready;
  assign w_take        = s_axi_wvalid & s_axi_wready;
  assign do_wr         = (aw_hold_q | aw_take) & (w_hold_q | w_take);
  assign wr_addr       = aw_hold_q ? awaddr_q : s_axi_awaddr;
  assign wr_byte       = w_hold_q ? wdata_q : s_axi_wdata[7:0];
  assign wr_lane       = w_hold_q ? wlane_q : s_axi_wstrb[0];
  assign wr_known      = known(wr_addr);
  assign we_ctrl       = do_wr & wr_lane & hit(wr_addr, OFF_CTRL);
  assign we_lo         = do_wr & wr_lane & hit(wr_addr, OFF_CNT_LO);
  assign we_hi         = do_wr & wr_lane & hit(wr_addr, OFF_CNT_HI);
  assign we_mask       = do_wr & wr_lane & hit(wr_addr, OFF_IRQ_MASK);
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= 8'h00;
      wlane_q   <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      aw_hold_q <= (aw_hold_q | aw_take) & ~do_wr;
      w_hold_q  <= (w_hold_q | w_take) & ~do_wr;
      if (aw_take) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_q <= s_axi_wdata[7:0];
        wlane_q <= s_axi_wstrb[0];
      end
      if (do_wr) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Unimplemented control bits never store
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= CTRL_RST;
      mask_q <= MASK_RST;
    end else begin
      if (we_ctrl) begin
        ctrl_q <= wr_byte & CTRL_IMPL_MASK;
      end
      if (we_mask) begin
        mask_q <= wr_byte[0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel
  assign s_axi_arready = ~rvalid_q;
  assign ar_take       = s_axi_arvalid & s_axi_arready;
  assign rd_known      = known(s_axi_araddr);
  assign stat_rd_clr   = ar_take & hit(s_axi_araddr, OFF_IRQ_STAT);
  assign rd_byte       = hit(s_axi_araddr, OFF_CTRL)     ? ctrl_q :
                         hit(s_axi_araddr, OFF_CNT_LO)   ? count_q[7:0] :
                         hit(s_axi_araddr, OFF_CNT_HI)   ? count_q[15:8] :
                         hit(s_axi_araddr, OFF_IRQ_STAT) ? {7'h00, stat_q} :
                         hit(s_axi_araddr, OFF_IRQ_MASK) ? {7'h00, mask_q} : 8'h00;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = {24'h000000, rbyte_q};
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rbyte_q  <= 8'h00;
      rresp_q  <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rbyte_q  <= rd_byte;
      rresp_q  <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_ctrl_top_zero: assert property (
    @(posedge sys_clk) disable iff (rst)
    we_ctrl |=> (ctrl_q[7:6] == 2'b00))
    else $error("control top bits stored");
  a_stop_holds: assert property (
    @(posedge sys_clk) disable iff (rst)
    (!ctrl_q[CTRL_ON_BIT] && !cc_special_event && !cnt_we) |=> $stable(count_q))
    else $error("count moved while stopped");
  a_event_clears: assert property (
    @(posedge sys_clk) disable iff (rst)
    cc_special_event |=> (count_q == CNT_RST))
    else $error("special event did not clear count");
  a_wrap_flags: assert property (
    @(posedge sys_clk) disable iff (rst)
    ovf_set |=> (count_q == CNT_RST) && stat_q)
    else $error("wrap did not clear count and flag");
  a_flag_irq: assert property (
    @(posedge sys_clk) disable iff (rst)
    (ovf_set && mask_q && !we_mask) |=> irq)
    else $error("unmasked overflow raised no interrupt");
  a_osc_pins: assert property (
    @(posedge sys_clk) disable iff (rst)
    ctrl_q[CTRL_OSC_BIT] |-> (osc_pin_oe_n == 2'b11) && (port_read_bits == 2'b00) && osc_run)
    else $error("oscillator pins not released");
  a_timer_spacing: assert property (
    @(posedge sys_clk) disable iff (rst)
    (inc && !ext_mode) ##1 !ext_mode |-> !inc [*3])
    else $error("timer counted faster than instruction rate");
  a_eight_spacing: assert property (
    @(posedge sys_clk) disable iff (rst)
    (presc_tick && ctrl_q[CTRL_PS_MSB:CTRL_PS_LSB] == 2'b11 && !cnt_we && !cc_special_event)
    |=> !presc_tick [*7])
    else $error("1:8 prescale passed ticks too close");
  a_sync_delay: assert property (
    @(posedge sys_clk) disable iff (rst)
    presc_tick ##1 (sync_path && ctrl_q[CTRL_ON_BIT]) [*2] |-> inc)
    else $error("synchronised tick not counted after two cycles");
  a_async_direct: assert property (
    @(posedge sys_clk) disable iff (rst)
    (ext_mode && ctrl_q[CTRL_SYNC_BIT] && presc_tick) |-> inc)
    else $error("raw external tick not counted at once");
  a_bresp_held: assert property (
    @(posedge sys_clk) disable iff (rst)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");

endmodule : stc_timer
